// ---- rmss_pkg.sv ----
// package: constants and carrier types for the radio mode and status sequencer
package rmss_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned MS_DIV        = CLK_HZ / 1000;
    localparam int unsigned WAKE_PULSE_US = 10;
    localparam int unsigned WAKE_PULSE_CYC = (WAKE_PULSE_US * (CLK_HZ / 1_000_000) > 0) ?
                                             WAKE_PULSE_US * (CLK_HZ / 1_000_000) : 1;
    localparam int unsigned TOOL_MS       = 1000;
    localparam int unsigned CMD_MS        = 500;
    localparam int unsigned FAULT_MS      = 250;
    localparam int unsigned REBOOT_MS     = 5000;
    localparam int unsigned WAKE_OK_MS    = 30;
    localparam int unsigned STUDY_PKTS    = 4;
    localparam int unsigned MARG_SHIFT    = 3;
    localparam int unsigned MARG_ADD_MS   = 60;
    localparam int unsigned OVERLAP_MS    = 100;
    localparam int unsigned CYCLES_RESTUDY = 100;
    localparam logic        STAT_IDLE     = 1'b1;
    localparam logic        STAT_ACTIVE   = 1'b0;

    typedef enum logic [2:0] {
        RMSS_OFF   = 3'b000,
        RMSS_ON    = 3'b001,
        RMSS_SLEEP = 3'b011,
        RMSS_WAKE  = 3'b010,
        RMSS_SAFE  = 3'b110,
        RMSS_BOOT  = 3'b111
    } rmss_state_t;

    typedef struct packed {
        logic rx_frame;
        logic tx_active;
        logic tx_tick;
        logic tool_conn;
        logic cmd_enabled;
        logic cmd_persist;
        logic fault;
    } rmss_status_t;

    typedef struct packed {
        logic sleep_cmd;
        logic restart_cmd;
        logic psave_en;
        logic pkt_good;
    } rmss_cmd_t;
endpackage

// ---- rmss_psave.sv ----
// power-save receive schedule: interval study, margin, sleep and slot window
`timescale 1ns/1ps
`default_nettype none
module rmss_psave
    import rmss_pkg::*;
#(
    parameter int unsigned TW = 16
) (
    // clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // control
    input  wire logic          i_ms_tick,
    input  wire logic          i_enable,
    input  wire logic          i_pkt_good,
    input  wire logic [TW-1:0] i_tx_time,
    // schedule
    output logic               o_radio_on,
    output logic               o_locked,
    output logic [TW-1:0]      o_tmin,
    output logic [TW-1:0]      o_tmarg,
    output logic [TW-1:0]      o_tsleep,
    output logic               o_lost
);
    initial begin
        if (TW < 10) $error("rmss_psave: TW too small");
    end

    logic [TW-1:0] since;
    logic [TW-1:0] tmin;
    logic [2:0]    npkt;
    logic [6:0]    ncyc;
    logic          sleeping;
    logic          lost;

    // margin is tmin/8 plus 60 ms; saturating subtraction keeps sleep non-negative
    wire [TW-1:0] tmarg     = (tmin >> MARG_SHIFT) + TW'(MARG_ADD_MS);
    wire [TW-1:0] sub1      = (tmin > tmarg) ? tmin - tmarg : '0;
    wire [TW-1:0] tsleep    = (sub1 > i_tx_time) ? sub1 - i_tx_time : '0;
    wire [TW-1:0] slot_min  = sub1;
    wire [TW-1:0] slot_max  = tmin + tmarg + TW'(OVERLAP_MS);
    wire          locked    = (npkt >= 3'(STUDY_PKTS));
    wire          in_slot   = (since >= slot_min) && (since <= slot_max);
    wire          missed    = locked && i_ms_tick && (since > slot_max);
    wire          restudy   = locked && i_pkt_good && (ncyc == 7'(CYCLES_RESTUDY - 1));
    wire          first_pkt = (npkt == 3'd0);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            since <= '0;
        end else if (!i_enable || missed) begin
            since <= '0;
        end else if (i_pkt_good) begin
            // a tick on the packet edge already counts toward the next interval
            since <= TW'(i_ms_tick);
        end else if (i_ms_tick && since != '1) begin
            since <= since + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tmin <= '1;
            npkt <= '0;
            ncyc <= '0;
            lost <= 1'b0;
        end else if (!i_enable || missed || restudy) begin
            tmin <= '1;
            npkt <= '0;
            ncyc <= '0;
            lost <= missed;
        end else if (i_pkt_good) begin
            lost <= 1'b0;
            // minimum refreshed after every good packet except the first of a study
            if (!first_pkt && since < tmin) tmin <= since;
            if (!locked) npkt <= npkt + 1'b1;
            else if (in_slot) ncyc <= ncyc + 1'b1;
        end
    end

    // radio sleeps from the packet until tsleep elapses, then listens through the slot
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sleeping <= 1'b0;
        end else begin
            sleeping <= i_enable && locked && !i_pkt_good && (since < tsleep);
        end
    end

    assign o_radio_on = !sleeping;
    assign o_locked   = locked;
    assign o_tmin     = tmin;
    assign o_tmarg    = tmarg;
    assign o_tsleep   = tsleep;
    assign o_lost     = lost;
endmodule
`default_nettype wire

// ---- rmss_top.sv ----
// top of the radio mode and status sequencer: power states, safe mode, status pin
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - searching for frame: status held high
// - status low throughout each received frame
// - light sleep: status held low
// - transmitting: toggle once per transmission interval
// - tool connected: toggle every 1 s
// - command mode via plus sequence: 500 ms
// - fault: toggle every 250 ms
// - fault enters safe mode, reboot after 5 s
// - no radio traffic in safe mode
// - enable high turns module on
// - enable low powers down, clears volatile state
// - sleep: radio off, wake on serial change
// - wake reply OK within 30 ms
// - stays awake until next sleep command
// - study four packets, refresh minimum each packet after the first
// - margin equals tmin over 8 plus 60
// - sleep equals tmin minus margin minus tx
// - restart study after 100 cycles
// - missed slot means lost packet, restudy
// - restart command reboots the processor
module rmss_top
    import rmss_pkg::*;
#(
    parameter int unsigned TW           = 16,
    parameter int unsigned MS_CYCLES    = MS_DIV,
    parameter int unsigned BOOT_CYCLES  = 16
) (
    // clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // pins from host
    input  wire logic          i_module_enable,
    input  wire logic          i_serial_transmit_data_in,
    // internal status and commands
    input  wire rmss_status_t  i_status,
    input  wire rmss_cmd_t     i_cmd,
    input  wire logic [TW-1:0] i_tx_time,
    // outputs
    output logic               o_stat,
    output logic               o_radio_on,
    output logic               o_radio_allow,
    output logic               o_serial_powered,
    output logic               o_core_reset,
    output logic               o_send_ok,
    output logic               o_psave_lost,
    output logic [TW-1:0]      o_tsleep,
    output rmss_state_t        o_state
);
    initial begin
        if (MS_CYCLES < 2) $error("rmss_top: MS_CYCLES too small");
        if (BOOT_CYCLES < 1) $error("rmss_top: BOOT_CYCLES too small");
        if (REBOOT_MS > 32'h0000_1fff) $error("rmss_top: ms timer too narrow");
        if (TOOL_MS > 32'h0000_1fff) $error("rmss_top: blink timer too narrow");
    end

    localparam int unsigned MSW = $clog2(MS_CYCLES);
    localparam int unsigned PW  = $clog2(WAKE_PULSE_CYC + 1);
    localparam int unsigned BW  = $clog2(BOOT_CYCLES + 1);

    function automatic logic tick_at(input logic [12:0] cnt, input int unsigned per_ms);
        tick_at = (cnt == 13'(per_ms - 1));
    endfunction

    // off and boot both hold the core and pull the status pin low
    function automatic logic is_held(input rmss_state_t s);
        is_held = (s == RMSS_OFF) || (s == RMSS_BOOT);
    endfunction

    // pin synchronisers: three stages, change counts once stages two and three agree
    logic [2:0] ena_sync;
    logic [2:0] txd_sync;
    logic       ena;
    logic       txd;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ena_sync <= 3'b000;
            txd_sync <= 3'b111;
            ena      <= 1'b0;
            txd      <= 1'b1;
        end else begin
            ena_sync <= {ena_sync[1:0], i_module_enable};
            txd_sync <= {txd_sync[1:0], i_serial_transmit_data_in};
            if (ena_sync[1] == ena_sync[2]) ena <= ena_sync[2];
            if (txd_sync[1] == txd_sync[2]) txd <= txd_sync[2];
        end
    end

    // millisecond enable
    logic [MSW-1:0] ms_div;
    wire            ms_tick = (ms_div == MSW'(MS_CYCLES - 1));

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) ms_div <= '0;
        else if (ms_tick) ms_div <= '0;
        else ms_div <= ms_div + 1'b1;
    end

    // wake detection: the line must hold its new level 10 us before it counts
    logic          txd_ref;
    logic [PW-1:0] pulse_cnt;
    wire           txd_diff  = (txd != txd_ref);
    wire           wake_seen = txd_diff && (pulse_cnt == PW'(WAKE_PULSE_CYC - 1));

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            txd_ref   <= 1'b1;
            pulse_cnt <= '0;
        end else if (!txd_diff) begin
            pulse_cnt <= '0;
        end else if (wake_seen) begin
            txd_ref   <= txd;
            pulse_cnt <= '0;
        end else begin
            pulse_cnt <= pulse_cnt + 1'b1;
        end
    end

    // main state machine
    rmss_state_t state;
    rmss_state_t next_state;
    logic [12:0] tmr_ms;
    logic [BW-1:0] boot_cnt;
    wire         boot_done = (boot_cnt == BW'(BOOT_CYCLES));
    wire         reboot_due = ms_tick && tick_at(tmr_ms, REBOOT_MS);
    wire         wake_due   = ms_tick && tick_at(tmr_ms, WAKE_OK_MS);

    always_comb begin
        next_state = state;
        case (state)
            RMSS_OFF: begin
                if (ena) next_state = RMSS_BOOT;
            end
            RMSS_BOOT: begin
                if (boot_done) next_state = RMSS_ON;
            end
            RMSS_ON: begin
                if (i_status.fault) next_state = RMSS_SAFE;
                else if (i_cmd.restart_cmd) next_state = RMSS_BOOT;
                else if (i_cmd.sleep_cmd) next_state = RMSS_SLEEP;
            end
            RMSS_SLEEP: begin
                if (wake_seen) next_state = RMSS_WAKE;
            end
            RMSS_WAKE: begin
                if (wake_due) next_state = RMSS_ON;
            end
            RMSS_SAFE: begin
                if (reboot_due) next_state = RMSS_BOOT;
            end
            default: next_state = RMSS_OFF;
        endcase
        if (!ena) next_state = RMSS_OFF;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) state <= RMSS_OFF;
        else state <= next_state;
    end

    // shared millisecond timer, cleared on every state change
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) tmr_ms <= '0;
        else if (next_state != state) tmr_ms <= '0;
        else if (ms_tick) tmr_ms <= tmr_ms + 1'b1;
    end

    // reboot hold: core kept in reset a few cycles so every volatile setting clears
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) boot_cnt <= '0;
        else if (state != RMSS_BOOT) boot_cnt <= '0;
        else if (!boot_done) boot_cnt <= boot_cnt + 1'b1;
    end

    // power-save scheduler
    wire           on_state  = (state == RMSS_ON);
    wire           ps_radio_on;
    wire [TW-1:0]  ps_tsleep;
    wire           ps_lost;

    rmss_psave #(
        .TW         (TW)
    ) u_psave (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_ms_tick  (ms_tick),
        .i_enable   (on_state && i_cmd.psave_en),
        .i_pkt_good (on_state && i_cmd.pkt_good),
        .i_tx_time  (i_tx_time),
        .o_radio_on (ps_radio_on),
        .o_locked   (),
        .o_tmin     (),
        .o_tmarg    (),
        .o_tsleep   (ps_tsleep),
        .o_lost     (ps_lost)
    );

    // blink timebase: an ms counter restarts at each toggle and toggles again at the selected rate's period
    // safe mode keeps the fault rate after the fault input has dropped
    wire         show_fault = (state == RMSS_SAFE) || i_status.fault;
    logic [12:0] blink_ms;
    logic        blink;
    logic        tx_tick_d;
    logic        tx_led;
    wire [12:0]  blink_per = show_fault          ? 13'(FAULT_MS) :
                             i_status.tool_conn   ? 13'(TOOL_MS)  : 13'(CMD_MS);
    wire         blink_hit = ms_tick && (blink_ms >= blink_per - 13'd1);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            blink_ms <= '0;
            blink    <= 1'b0;
        end else if (state == RMSS_OFF) begin
            blink_ms <= '0;
            blink    <= 1'b0;
        end else if (blink_hit) begin
            blink_ms <= '0;
            blink    <= ~blink;
        end else if (ms_tick) begin
            blink_ms <= blink_ms + 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tx_tick_d <= 1'b0;
            tx_led    <= 1'b0;
        end else if (state == RMSS_OFF) begin
            tx_tick_d <= i_status.tx_tick;
            tx_led    <= 1'b0;
        end else begin
            tx_tick_d <= i_status.tx_tick;
            if (i_status.tx_tick && !tx_tick_d) tx_led <= ~tx_led;
        end
    end

    // status selection in priority order; safe mode forces the fault rate
    wire show_cmd   = i_status.cmd_enabled && !i_status.cmd_persist;
    wire is_sleep   = (state == RMSS_SLEEP);
    wire next_stat  = is_held(state)       ? STAT_ACTIVE :
                      show_fault           ? blink :
                      is_sleep             ? STAT_ACTIVE :
                      i_status.tool_conn   ? blink :
                      show_cmd             ? blink :
                      i_status.tx_active   ? tx_led :
                      i_status.rx_frame    ? STAT_ACTIVE :
                                             STAT_IDLE;

    // radio allowed only when on and not in safe mode or command mode
    wire radio_ok = on_state && !i_status.fault && !i_status.cmd_enabled;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_stat           <= STAT_ACTIVE;
            o_radio_on       <= 1'b0;
            o_radio_allow    <= 1'b0;
            o_serial_powered <= 1'b0;
            o_core_reset     <= 1'b1;
            o_send_ok        <= 1'b0;
            o_psave_lost     <= 1'b0;
            o_tsleep         <= '0;
        end else begin
            o_stat           <= next_stat;
            o_radio_on       <= radio_ok && ps_radio_on;
            o_radio_allow    <= radio_ok;
            o_serial_powered <= (state != RMSS_OFF);
            o_core_reset     <= is_held(state);
            o_send_ok        <= wake_due && (state == RMSS_WAKE);
            o_psave_lost     <= ps_lost;
            o_tsleep         <= ps_tsleep;
        end
    end

    assign o_state = state;
endmodule
`default_nettype wire

// ---- rmss_top_properties.sv ----
// checker: timed relations at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rmss_top_properties
    import rmss_pkg::*;
#(
    parameter int unsigned TW          = 16,
    parameter int unsigned MS_CYCLES   = MS_DIV,
    parameter int unsigned BOOT_CYCLES = 16
) (
    // clock and reset
    input wire logic         i_clock,
    input wire logic         i_rst,
    // watched inputs
    input wire logic         i_module_enable,
    input wire rmss_status_t i_status,
    input wire rmss_cmd_t    i_cmd,
    // watched outputs
    input wire logic         o_stat,
    input wire logic         o_radio_on,
    input wire logic         o_radio_allow,
    input wire logic         o_serial_powered,
    input wire logic         o_core_reset,
    input wire logic         o_send_ok,
    input wire rmss_state_t  o_state
);
    localparam int WAKE_MAX  = (WAKE_OK_MS + 1) * MS_CYCLES + 4;
    localparam int BLINK_MAX = (FAULT_MS + 1) * MS_CYCLES + 4;
    logic [31:0] safe_cnt;
    logic [31:0] hold_cnt;
    wire         in_safe = (o_state == RMSS_SAFE);
    // counters stand in for long repetitions, which the tools cannot unroll
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            safe_cnt <= '0;
            hold_cnt <= '0;
        end else begin
            safe_cnt <= in_safe ? safe_cnt + 1 : '0;
            hold_cnt <= (in_safe && o_stat == $past(o_stat)) ? hold_cnt + 1 : '0;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence wake_start;
        $rose(o_state == RMSS_WAKE);
    endsequence
    sequence ok_reply;
        ##[1:WAKE_MAX] o_send_ok;
    endsequence
    idle_high_a: assert property ((o_state == RMSS_ON && i_status == 7'h00) [*2] |-> o_stat)
        else $error("status not high while idle");
    rx_low_a: assert property ((o_state == RMSS_ON && i_status == 7'h40) [*2] |-> !o_stat)
        else $error("status not low during frame");
    sleep_low_a: assert property ((o_state == RMSS_SLEEP) [*2] |-> !o_stat && !o_radio_on && o_serial_powered)
        else $error("sleep outputs wrong");
    safe_enter_a: assert property (o_state == RMSS_ON && i_status.fault |=> in_safe)
        else $error("fault did not enter safe mode");
    reboot_time_a: assert property (o_state == RMSS_BOOT && $past(o_state) == RMSS_SAFE |->
        safe_cnt >= (REBOOT_MS - 1) * MS_CYCLES && safe_cnt <= (REBOOT_MS + 1) * MS_CYCLES + 2)
        else $error("safe mode reboot time wrong");
    fault_blink_a: assert property (in_safe |-> hold_cnt <= BLINK_MAX)
        else $error("safe mode blink too slow");
    safe_radio_a: assert property (in_safe |=> !o_radio_allow && !o_radio_on)
        else $error("radio allowed in safe mode");
    off_clear_a: assert property ((!i_module_enable) [*7] |->
        o_state == RMSS_OFF && o_core_reset && !o_serial_powered && !o_radio_allow)
        else $error("enable low did not power down");
    wake_ok_a: assert property (wake_start |-> ok_reply)
        else $error("no wake reply in time");
    restart_a: assert property (o_state == RMSS_ON && i_cmd.restart_cmd && !i_status.fault |=>
        o_state == RMSS_BOOT)
        else $error("restart did not reboot");
    boot_on_a: assert property ($fell(o_state == RMSS_OFF) |-> o_state == RMSS_BOOT)
        else $error("power on skipped boot");
endmodule
bind rmss_top rmss_top_properties #(.TW(TW), .MS_CYCLES(MS_CYCLES), .BOOT_CYCLES(BOOT_CYCLES))
    u_rmss_top_properties (.i_clock(i_clock), .i_rst(i_rst), .i_module_enable(i_module_enable),
    .i_status(i_status), .i_cmd(i_cmd), .o_stat(o_stat), .o_radio_on(o_radio_on),
    .o_radio_allow(o_radio_allow), .o_serial_powered(o_serial_powered),
    .o_core_reset(o_core_reset), .o_send_ok(o_send_ok), .o_state(o_state));
`default_nettype wire

// ---- rmss_host_model.sv ----
// host terminal model: enable pin and serial transmit line
`timescale 1ns/1ps
`default_nettype none
module rmss_host_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // requests from the bench
    input  wire logic        i_power,
    input  wire logic        i_wake_go,
    input  wire logic [15:0] i_wake_len,
    // pins toward the module
    output logic             o_module_enable,
    output logic             o_serial_transmit_data_in
);
    logic [15:0] low_cnt;
    // a short length models a glitch that must not wake the module
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_module_enable <= 1'b0;
            low_cnt         <= 16'h0000;
        end else begin
            o_module_enable <= i_power;
            if (i_wake_go && low_cnt == 16'h0000) begin
                low_cnt <= i_wake_len;
            end else if (low_cnt != 16'h0000) begin
                low_cnt <= low_cnt - 16'h0001;
            end
        end
    end
    // line idles high as the pull-up leaves it
    assign o_serial_transmit_data_in = (low_cnt == 16'h0000);
endmodule
`default_nettype wire

// ---- radio_mode_status_sequencer_bench.sv ----
// self-checking bench for the radio mode and status sequencer
`timescale 1ns/1ps
`default_nettype none
module radio_mode_status_sequencer_bench;
    import rmss_pkg::*;
    localparam int unsigned MSC = 6;
    logic         i_clock  = 1'b0;
    logic         i_rst    = 1'b1;
    logic         power    = 1'b0;
    logic         wake_go  = 1'b0;
    logic [15:0]  wake_len = 16'h0000;
    rmss_status_t st       = '0;
    rmss_cmd_t    cmd      = '0;
    logic [15:0]  tx_time  = 16'h0000;
    logic         ena, txd, o_stat, o_radio_on, o_radio_allow, o_serial_powered;
    logic         o_core_reset, o_send_ok, o_psave_lost;
    logic [15:0]  o_tsleep;
    rmss_state_t  o_state;
    int           error_cnt = 0;
    int           samples_checked = 0;
    rmss_host_model u_rmss_host_model (.i_clock(i_clock), .i_rst(i_rst), .i_power(power),
        .i_wake_go(wake_go), .i_wake_len(wake_len), .o_module_enable(ena), .o_serial_transmit_data_in(txd));
    rmss_top #(.TW(16), .MS_CYCLES(MSC), .BOOT_CYCLES(16)) u_rmss_top (.i_clock(i_clock), .i_rst(i_rst),
        .i_module_enable(ena), .i_serial_transmit_data_in(txd), .i_status(st), .i_cmd(cmd),
        .i_tx_time(tx_time), .o_stat(o_stat), .o_radio_on(o_radio_on), .o_radio_allow(o_radio_allow),
        .o_serial_powered(o_serial_powered), .o_core_reset(o_core_reset), .o_send_ok(o_send_ok),
        .o_psave_lost(o_psave_lost), .o_tsleep(o_tsleep), .o_state(o_state));
    always #4 i_clock = ~i_clock;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic bail(input int k, input int lim);
        if (k >= lim) begin
            error_cnt++;
            results();
        end
    endtask
    task automatic wait_st(input rmss_state_t s, input int lim);
        int k;
        for (k = 0; k < lim && o_state !== s; k++) @(negedge i_clock);
        bail(k, lim);
    endtask
    // the last of three toggle gaps: the first may be cut short by the mode change
    task automatic period(output int p);
        logic v;
        for (int k = 0; k < 3; k++) begin
            v = o_stat;
            for (p = 0; p < 20000 && o_stat === v; p++) @(negedge i_clock);
        end
        bail(p, 20000);
    endtask
    task automatic set_st(input logic [6:0] v);
        @(posedge i_clock) st <= v;
        cyc(2);
    endtask
    task automatic pulse_cmd(input logic [3:0] c);
        @(posedge i_clock) cmd <= cmd | c;
        @(posedge i_clock) cmd <= cmd & ~c;
    endtask
    task automatic wake(input logic [15:0] n);
        @(posedge i_clock) wake_go <= 1'b1;
        wake_len <= n;
        @(posedge i_clock) wake_go <= 1'b0;
    endtask
    function automatic logic [15:0] exp_sleep(input int tmin, input int tx);
        int s;
        s = tmin - (tmin / 8 + 60) - tx;
        return (s < 0) ? 16'h0000 : s[15:0];
    endfunction
    initial begin
        int p, tmin, gap, tx, k;
        logic v;
        longint t0;
        void'($urandom(32'h6b72_304f));
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        power <= 1'b1;
        cyc(1);
        wait_st(RMSS_ON, 60);
        cyc(2);
        chk(o_core_reset, 16'h0000);
        chk(o_stat, 16'h0001);
        set_st(7'h40);
        chk(o_stat, 16'h0000);
        set_st(7'h60);
        for (k = 0; k < 4; k++) begin
            v = o_stat;
            set_st(7'h70);
            cyc(1);
            chk(o_stat, !v);
            set_st(7'h60);
            cyc($urandom_range(1, 20));
        end
        $display("test status levels done");
        set_st(7'h2c);
        period(p);
        chk(p, 1000 * MSC);
        set_st(7'h04);
        period(p);
        chk(p, 500 * MSC);
        set_st(7'h06);
        chk(o_stat, 16'h0001);
        cyc(600 * MSC);
        chk(o_stat, 16'h0001);
        $display("test blink rates done");
        set_st(7'h00);
        pulse_cmd(4'h8);
        cyc(3);
        chk(o_state, RMSS_SLEEP);
        chk(o_stat, 16'h0000);
        chk({o_radio_on, o_serial_powered}, 16'h0001);
        wake(16'd600);
        cyc(800);
        chk(o_state, RMSS_SLEEP);
        wake(16'd1300);
        wait_st(RMSS_WAKE, 1500);
        for (k = 0; k < 40 * MSC && o_send_ok !== 1'b1; k++) @(negedge i_clock);
        chk(k >= 28 * MSC && k <= 31 * MSC, 16'h0001);
        cyc(100 * MSC);
        chk(o_state, RMSS_ON);
        $display("test sleep and wake done");
        pulse_cmd(4'h4);
        cyc(1);
        chk(o_state, RMSS_BOOT);
        wait_st(RMSS_ON, 40);
        $display("test restart done");
        @(posedge i_clock) cmd <= 4'h2;
        tx = $urandom_range(0, 100);
        tx_time <= tx[15:0];
        tmin = 65535;
        pulse_cmd(4'h1);
        for (k = 0; k < 4; k++) begin
            gap = $urandom_range(400, 450);
            tmin = (gap < tmin) ? gap : tmin;
            cyc(gap * MSC - 1);
            pulse_cmd(4'h1);
        end
        cyc(3);
        chk(o_tsleep, exp_sleep(tmin, tx));
        cyc(700 * MSC);
        chk(o_psave_lost, 16'h0001);
        for (k = 0; k < 104; k++) begin
            pulse_cmd(4'h1);
            cyc(10 * MSC - 1);
            if (k == 102) chk(o_tsleep, exp_sleep(10, tx));
        end
        chk(o_tsleep, exp_sleep(65535, tx));
        $display("test power save done");
        @(posedge i_clock) cmd <= 4'h0;
        set_st(7'h0d);
        t0 = $time;
        chk(o_state, RMSS_SAFE);
        chk(o_radio_allow, 16'h0000);
        period(p);
        chk(p, 250 * MSC);
        set_st(7'h00);
        wait_st(RMSS_BOOT, 5100 * MSC);
        chk(($time - t0) / 8 > 4997 * MSC && ($time - t0) / 8 < 5001 * MSC, 16'h0001);
        wait_st(RMSS_ON, 40);
        $display("test safe mode done");
        @(posedge i_clock) power <= 1'b0;
        cyc(10);
        chk(o_state, RMSS_OFF);
        chk({o_core_reset, o_serial_powered, o_psave_lost}, 16'h0004);
        $display("test power off done");
        results();
    end
endmodule
`default_nettype wire
